// [shared/sor_pkg.sv]
package sor_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [6:0] OFS_LEVEL_MOD   = 7'h2e;
  localparam logic [6:0] OFS_A_SRC_B_LVL = 7'h2f;
  localparam logic [6:0] OFS_B_SRC       = 7'h30;
  localparam logic [6:0] OFS_PIN_DRIVE   = 7'h3b;
  localparam logic [6:0] OFS_LOCK_IND    = 7'h3d;
  localparam logic [6:0] OFS_RSVD_62     = 7'h3e;
  localparam logic [6:0] OFS_FAST_CAL    = 7'h40;
  localparam logic [6:0] OFS_LOCK_BAND   = 7'h44;
  localparam logic [6:0] OFS_CAP_CODE    = 7'h45;
  localparam logic [6:0] OFS_BIAS_CODE   = 7'h46;

  // values after reset, whole register (unnamed bits zero)
  localparam logic [15:0] RST_LEVEL_MOD   = 16'h0f83;
  localparam logic [15:0] RST_A_SRC_B_LVL = 16'h0000;
  localparam logic [15:0] RST_B_SRC       = 16'h0000;
  localparam logic [15:0] RST_PIN_DRIVE   = 16'h0000;
  localparam logic [15:0] RST_LOCK_IND    = 16'h0001;
  localparam logic [15:0] RST_RSVD_62     = 16'h0000;
  localparam logic [15:0] RST_FAST_CAL    = 16'h006f;

  // field positions
  localparam int A_LVL_LSB   = 8;
  localparam int B_LVL_LSB   = 0;
  localparam int LVL_W       = 6;
  localparam int B_SHDN_BIT  = 7;
  localparam int A_SHDN_BIT  = 6;
  localparam int ORDER_LSB   = 0;
  localparam int ORDER_W     = 3;
  localparam int A_SRC_LSB   = 11;
  localparam int B_SRC_LSB   = 0;
  localparam int SRC_W       = 2;
  localparam int HDRV_BIT    = 5;
  localparam int LDTYPE_BIT  = 0;
  localparam int ACAL_BIT    = 9;
  localparam int FCAL_BIT    = 8;
  localparam int ASTEP_LSB   = 5;
  localparam int ASTEP_W     = 3;
  localparam int FSTEP_LSB   = 0;
  localparam int FSTEP_W     = 4;
  localparam int VTUNE_LSB   = 9;
  localparam int CORE_LSB    = 5;

  // level code thresholds and encodings
  localparam logic [5:0] LVL_LINEAR_MAX = 6'h1f;
  localparam logic [5:0] LVL_BOOST_MIN  = 6'h30;
  localparam logic [1:0] SRC_DIVIDER    = 2'h0;
  localparam logic [1:0] SRC_OSC        = 2'h1;
  localparam logic [1:0] VT_LOCKED      = 2'h2;
  localparam logic [1:0] VT_INVALID     = 2'h1;
  localparam logic [2:0] ORDER_INTEGER  = 3'h0;
  localparam logic [2:0] ORDER_MAX      = 3'h4;

  typedef struct packed {
    logic [2:0] core;
    logic [7:0] cap;
    logic [8:0] bias;
  } sor_cal_result_t;

  typedef struct packed {
    logic [5:0] level;
    logic       shutdown;
    logic       boost;
    logic       from_osc;
    logic       from_divider;
  } sor_buffer_ctrl_t;

  typedef struct packed {
    logic [2:0] order;
    logic       integer_mode;
    logic       amp_fast;
    logic [2:0] amp_step;
    logic       freq_fast;
    logic [3:0] freq_step;
  } sor_synth_ctrl_t;

endpackage

// [hw/sor_regs.sv]
`timescale 1ns/1ps
// Operation
// - first output level, six bits, 0..31 linear, 48..63 boost, resets to 15
// - second output level, same code ranges, resets to 0
// - second output shutdown bit, set powers down, resets to 1
// - first output shutdown bit, set powers down, resets to 0
// - modulator order: 0 integer, 1..4 sigma-delta order, resets to third
// - per-output source: 1 oscillator, 0 channel divider, 2 and 3 reserved
// - pin high-drive bit selects stronger status pin drive, resets to 0
// - lock type 0: status pin high once calibration completed successfully
// - lock type 1 (reset): status pin follows tuning-voltage lock
// - fast amplitude calibration enable, resets to 0
// - fast frequency calibration enable, resets to 0
// - amplitude step, effective only while fast amplitude cal enabled, resets 3
// - frequency step, effective only while fast frequency cal enabled, resets 15
// - read-only tuning lock state: 2 locked, 1 invalid, 0 or 3 unlocked
// - read-only selected oscillator core number 1..7
// - read-only eight-bit capacitor code from calibration
// - read-only nine-bit bias code from calibration
module sor_regs (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic [6:0]                reg_addr_i,
  input  wire logic [15:0]               reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output logic      [15:0]               reg_rdata_o,
  input  wire logic                      mux_pin_function_select_i,
  input  wire logic                      cal_done_i,
  input  wire logic [1:0]                tuning_lock_i,
  input  wire logic                      cal_update_toggle_i,
  input  wire sor_pkg::sor_cal_result_t  cal_result_i,
  output sor_pkg::sor_buffer_ctrl_t      first_output_o,
  output sor_pkg::sor_buffer_ctrl_t      second_output_o,
  output sor_pkg::sor_synth_ctrl_t       synth_ctrl_o,
  output logic                           mux_pin_high_drive_o,
  output logic                           multiplexed_status_pin_o
);

  typedef struct packed {
    logic [15:0]               level_mod;
    logic [15:0]               a_src_b_lvl;
    logic [15:0]               b_src;
    logic [15:0]               pin_drive;
    logic [15:0]               lock_ind;
    logic [15:0]               rsvd_62;
    logic [15:0]               fast_cal;
    logic [1:0]                vt_s1;
    logic [1:0]                vt_s2;
    logic                      done_s1;
    logic                      done_s2;
    logic                      tog_s1;
    logic                      tog_s2;
    logic                      tog_s3;
    sor_pkg::sor_cal_result_t  cal;
    logic [15:0]               rdata;
    logic                      pin;
    sor_pkg::sor_buffer_ctrl_t out_a;
    sor_pkg::sor_buffer_ctrl_t out_b;
    sor_pkg::sor_synth_ctrl_t  synth;
  } sor_state_t;

  sor_state_t st;
  sor_state_t next_st;

  // decode a buffer's level and source into its control word
  function automatic sor_pkg::sor_buffer_ctrl_t buf_ctrl(input logic [5:0] lvl,
                                                          input logic       shdn,
                                                          input logic [1:0] src);
    sor_pkg::sor_buffer_ctrl_t c;
    c.level        = lvl;
    c.shutdown     = shdn;
    c.boost        = (lvl >= sor_pkg::LVL_BOOST_MIN);
    c.from_osc     = (src == sor_pkg::SRC_OSC);
    c.from_divider = (src == sor_pkg::SRC_DIVIDER);
    return c;
  endfunction

  // next-state logic for the whole block
  always_comb begin
    logic [1:0] vt;
    logic       lock_ind;
    vt       = 2'h0;
    lock_ind = 1'b0;
    next_st  = st;

    // two-flop synchronisers; the first stage feeds only the second
    next_st.vt_s1   = tuning_lock_i;
    next_st.vt_s2   = st.vt_s1;
    next_st.done_s1 = cal_done_i;
    next_st.done_s2 = st.done_s1;
    next_st.tog_s1  = cal_update_toggle_i;
    next_st.tog_s2  = st.tog_s1;
    next_st.tog_s3  = st.tog_s2;

    // result words are held stable by the source across each toggle,
    // so sampling them on the synchronised edge is safe
    if (st.tog_s2 != st.tog_s3) begin
      next_st.cal = cal_result_i;
    end

    // register writes; readback offsets have no write path
    if (reg_wr_i) begin
      case (reg_addr_i)
        sor_pkg::OFS_LEVEL_MOD: begin
          next_st.level_mod = reg_wdata_i;
        end
        sor_pkg::OFS_A_SRC_B_LVL: begin
          next_st.a_src_b_lvl = reg_wdata_i;
        end
        sor_pkg::OFS_B_SRC: begin
          next_st.b_src = reg_wdata_i;
        end
        sor_pkg::OFS_PIN_DRIVE: begin
          next_st.pin_drive = reg_wdata_i;
        end
        sor_pkg::OFS_LOCK_IND: begin
          next_st.lock_ind = reg_wdata_i;
        end
        sor_pkg::OFS_RSVD_62: begin
          next_st.rsvd_62 = reg_wdata_i;
        end
        sor_pkg::OFS_FAST_CAL: begin
          next_st.fast_cal = reg_wdata_i;
        end
        default: begin
          next_st.rdata = st.rdata;
        end
      endcase
    end

    // read data stands only in the cycle after the strobe
    next_st.rdata = 16'h0000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        sor_pkg::OFS_LEVEL_MOD:   next_st.rdata = st.level_mod;
        sor_pkg::OFS_A_SRC_B_LVL: next_st.rdata = st.a_src_b_lvl;
        sor_pkg::OFS_B_SRC:       next_st.rdata = st.b_src;
        sor_pkg::OFS_PIN_DRIVE:   next_st.rdata = st.pin_drive;
        sor_pkg::OFS_LOCK_IND:    next_st.rdata = st.lock_ind;
        sor_pkg::OFS_RSVD_62:     next_st.rdata = st.rsvd_62;
        sor_pkg::OFS_FAST_CAL:    next_st.rdata = st.fast_cal;
        sor_pkg::OFS_LOCK_BAND: begin
          next_st.rdata[sor_pkg::VTUNE_LSB +: 2] = st.vt_s2;
          next_st.rdata[sor_pkg::CORE_LSB +: 3]  = st.cal.core;
        end
        sor_pkg::OFS_CAP_CODE:    next_st.rdata[7:0] = st.cal.cap;
        sor_pkg::OFS_BIAS_CODE:   next_st.rdata[8:0] = st.cal.bias;
        default:                  next_st.rdata = 16'h0000;
      endcase
    end

    // buffer controls follow the stored fields
    next_st.out_a = buf_ctrl(st.level_mod[sor_pkg::A_LVL_LSB +: sor_pkg::LVL_W],
                             st.level_mod[sor_pkg::A_SHDN_BIT],
                             st.a_src_b_lvl[sor_pkg::A_SRC_LSB +: sor_pkg::SRC_W]);
    next_st.out_b = buf_ctrl(st.a_src_b_lvl[sor_pkg::B_LVL_LSB +: sor_pkg::LVL_W],
                             st.level_mod[sor_pkg::B_SHDN_BIT],
                             st.b_src[sor_pkg::B_SRC_LSB +: sor_pkg::SRC_W]);

    // modulator and calibration controls; steps are zero while disabled
    next_st.synth.order        = st.level_mod[sor_pkg::ORDER_LSB +: sor_pkg::ORDER_W];
    next_st.synth.integer_mode = (next_st.synth.order == sor_pkg::ORDER_INTEGER);
    next_st.synth.amp_fast     = st.fast_cal[sor_pkg::ACAL_BIT];
    next_st.synth.freq_fast    = st.fast_cal[sor_pkg::FCAL_BIT];
    next_st.synth.amp_step     = st.fast_cal[sor_pkg::ACAL_BIT] ?
                                 st.fast_cal[sor_pkg::ASTEP_LSB +: sor_pkg::ASTEP_W] : 3'h0;
    next_st.synth.freq_step    = st.fast_cal[sor_pkg::FCAL_BIT] ?
                                 st.fast_cal[sor_pkg::FSTEP_LSB +: sor_pkg::FSTEP_W] : 4'h0;

    // lock indication, shown only when the pin function selects it
    vt = st.vt_s2;
    if (st.lock_ind[sor_pkg::LDTYPE_BIT]) begin
      lock_ind = (vt == sor_pkg::VT_LOCKED);
    end else begin
      lock_ind = st.done_s2;
    end
    next_st.pin = mux_pin_function_select_i & lock_ind;
  end

  // single state register; reset loads documented defaults
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st             <= '0;
      st.level_mod   <= sor_pkg::RST_LEVEL_MOD;
      st.a_src_b_lvl <= sor_pkg::RST_A_SRC_B_LVL;
      st.b_src       <= sor_pkg::RST_B_SRC;
      st.pin_drive   <= sor_pkg::RST_PIN_DRIVE;
      st.lock_ind    <= sor_pkg::RST_LOCK_IND;
      st.rsvd_62     <= sor_pkg::RST_RSVD_62;
      st.fast_cal    <= sor_pkg::RST_FAST_CAL;
      st.out_a.level    <= 6'h0f;
      st.out_a.from_divider <= 1'b1;
      st.out_b.shutdown <= 1'b1;
      st.out_b.from_divider <= 1'b1;
      st.synth.order     <= 3'h3;
      st.synth.amp_step  <= 3'h0;
      st.synth.freq_step <= 4'h0;
    end else begin
      st <= next_st;
    end
  end

  // every data output comes straight from the state register
  assign reg_rdata_o              = st.rdata;
  assign first_output_o           = st.out_a;
  assign second_output_o          = st.out_b;
  assign synth_ctrl_o             = st.synth;
  assign mux_pin_high_drive_o     = st.pin_drive[sor_pkg::HDRV_BIT];
  assign multiplexed_status_pin_o = st.pin;

endmodule

// [verif/sor_cal_model.sv]
`timescale 1ns/1ps
module sor_cal_model (
  output logic                     cal_done_o,
  output logic [1:0]               lock_o,
  output logic                     toggle_o,
  output sor_pkg::sor_cal_result_t res_o
);
  logic lclk;
  // free link clock, phase unrelated to the block clock
  initial begin
    lclk = 1'b0;
    #7;
    forever #24 lclk = ~lclk;
  end
  // idle state: no calibration result yet
  initial begin
    cal_done_o = 1'b0;
    lock_o = 2'h0;
    toggle_o = 1'b0;
    res_o = '0;
  end
  // result held a full link cycle either side of the toggle, beyond the 3 clk need
  task automatic publish(input sor_pkg::sor_cal_result_t r);
    @(posedge lclk) res_o <= r;
    @(posedge lclk) toggle_o <= ~toggle_o;
    @(posedge lclk);
  endtask
  task automatic set_state(input logic done, input logic [1:0] lk);
    @(posedge lclk) cal_done_o <= done;
    lock_o <= lk;
  endtask
endmodule

// [verif/sor_regs_checker.sv]
`timescale 1ns/1ps
module sor_regs_checker (
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input wire logic [6:0]                reg_addr_i,
  input wire logic [15:0]               reg_wdata_i,
  input wire logic                      reg_wr_i,
  input wire logic                      reg_rd_i,
  input wire logic [15:0]               reg_rdata_o,
  input wire logic                      mux_pin_function_select_i,
  input wire sor_pkg::sor_buffer_ctrl_t first_output_o,
  input wire sor_pkg::sor_buffer_ctrl_t second_output_o,
  input wire sor_pkg::sor_synth_ctrl_t  synth_ctrl_o,
  input wire logic                      mux_pin_high_drive_o,
  input wire logic                      multiplexed_status_pin_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // read data only in the cycle after a read strobe
  a_read_one_cycle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside read cycle");
  a_high_drive: assert property (reg_wr_i && reg_addr_i == 7'h3b |=> mux_pin_high_drive_o == $past(reg_wdata_i[5]))
    else $error("high drive bit wrong");
  a_boost_code: assert property (first_output_o.boost == (first_output_o.level >= 6'h30))
    else $error("boost flag wrong");
  a_source_sel: assert property (reg_wr_i && reg_addr_i == 7'h2f |=> ##1
    first_output_o.from_osc == ($past(reg_wdata_i[12:11], 2) == 2'h1))
    else $error("source select wrong");
  a_order_field: assert property (reg_wr_i && reg_addr_i == 7'h2e |=> ##1
    synth_ctrl_o.order == $past(reg_wdata_i[2:0], 2))
    else $error("modulator order wrong");
  a_b_shutdown: assert property (reg_wr_i && reg_addr_i == 7'h2e |=> ##1
    second_output_o.shutdown == $past(reg_wdata_i[7], 2))
    else $error("second shutdown wrong");
  a_amp_gate: assert property (!synth_ctrl_o.amp_fast |-> synth_ctrl_o.amp_step == 3'h0)
    else $error("amplitude step leaks");
  a_freq_gate: assert property (!synth_ctrl_o.freq_fast |-> synth_ctrl_o.freq_step == 4'h0)
    else $error("frequency step leaks");
  a_pin_unselected: assert property (!mux_pin_function_select_i [*3] |-> !multiplexed_status_pin_o)
    else $error("status pin while unselected");
endmodule
bind sor_regs sor_regs_checker chk (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .mux_pin_function_select_i(mux_pin_function_select_i), .first_output_o(first_output_o),
  .second_output_o(second_output_o), .synth_ctrl_o(synth_ctrl_o),
  .mux_pin_high_drive_o(mux_pin_high_drive_o), .multiplexed_status_pin_o(multiplexed_status_pin_o));

// [verif/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic                      clk_i, rst_i, reg_wr_i, reg_rd_i, sel, done, tgl, hd, pin;
  logic [6:0]                reg_addr_i;
  logic [15:0]               reg_wdata_i, reg_rdata_o;
  logic [1:0]                lk;
  sor_pkg::sor_cal_result_t  res;
  sor_pkg::sor_buffer_ctrl_t fo, so;
  sor_pkg::sor_synth_ctrl_t  sc;
  int                        err_total = 0;
  int                        n_compared = 0;
  logic [6:0]  ofs [7] = '{7'h2e, 7'h2f, 7'h30, 7'h3b, 7'h3d, 7'h3e, 7'h40};
  logic [15:0] rv [7] = '{16'h0f83, 16'h0, 16'h0, 16'h0, 16'h0001, 16'h0, 16'h006f};
  logic [15:0] wv [7] = '{16'h3f44, 16'h0820, 16'h0002, 16'h0020, 16'h0, 16'h0, 16'h03a5};
  sor_regs dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mux_pin_function_select_i(sel),
    .cal_done_i(done), .tuning_lock_i(lk), .cal_update_toggle_i(tgl), .cal_result_i(res),
    .first_output_o(fo), .second_output_o(so), .synth_ctrl_o(sc), .mux_pin_high_drive_o(hd),
    .multiplexed_status_pin_o(pin));
  sor_cal_model cal (.cal_done_o(done), .lock_o(lk), .toggle_o(tgl), .res_o(res));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask
  // outputs lag the register by one cycle; wait past that
  task automatic st(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic s_reset;
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) rd(ofs[i], rv[i]);
    chk({10'h0, fo.level}, 16'h000f);
    chk({14'h0, so.shutdown, fo.shutdown}, 16'h0002);
  endtask
  task automatic s_write;
    for (int i = 0; i < 7; i++) wr(ofs[i], wv[i]);
    for (int i = 0; i < 7; i++) rd(ofs[i], wv[i]);
    rd(7'h10, 16'h0); // unmapped
    chk({fo.level, fo.boost, fo.shutdown, so.level, so.boost, so.shutdown}, 16'hff80);
    chk({13'h0, sc.order}, 16'h0004);
    chk({8'h0, sc.amp_step, sc.freq_step, hd}, 16'h00ab);
    wr(7'h45, 16'hffff);
    rd(7'h45, 16'h0);
  endtask
  task automatic s_modes;
    for (int c = 0; c < 5; c++) begin
      wr(7'h2e, 16'(c));
      st(2);
      chk({15'h0, sc.integer_mode}, 16'(c == 0));
    end
    for (int c = 0; c < 4; c++) begin
      wr(7'h2f, 16'(c) << 11);
      wr(7'h30, 16'(c));
      st(2);
      chk({fo.from_osc, fo.from_divider, so.from_osc, so.from_divider}, {2{c == 1, c == 0}});
    end
    wr(7'h40, 16'h00a5);
    st(2);
    chk({7'h0, sc.amp_fast, sc.freq_fast, sc.amp_step, sc.freq_step}, 16'h0);
    wr(7'h40, 16'h02a5);
    st(2);
    chk({7'h0, sc.amp_fast, sc.freq_fast, sc.amp_step, sc.freq_step}, 16'h0150);
  endtask
  task automatic pin_is(input logic d, input logic [1:0] l, input logic e);
    cal.set_state(d, l);
    st(10);
    chk({15'h0, pin}, {15'h0, e});
  endtask
  task automatic s_pin;
    @(posedge clk_i) sel <= 1'b1;
    wr(7'h3d, 16'h0001);
    pin_is(1'b0, 2'h2, 1'b1);
    pin_is(1'b1, 2'h3, 1'b0);
    pin_is(1'b1, 2'h0, 1'b0);
    wr(7'h3d, 16'h0000);
    pin_is(1'b1, 2'h0, 1'b1);
    pin_is(1'b0, 2'h2, 1'b0);
    cal.set_state(1'b1, 2'h2);
    @(posedge clk_i) sel <= 1'b0;
    pin_is(1'b1, 2'h2, 1'b0);
  endtask
  task automatic s_readback;
    cal.publish('{core: 3'h5, cap: 8'ha5, bias: 9'h1c3});
    st(10);
    rd(7'h44, 16'h04a0);
    rd(7'h45, 16'h00a5);
    wr(7'h46, 16'h0000);
    rd(7'h46, 16'h01c3);
  endtask
  task automatic give_verdict;
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // cut a hang short
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    give_verdict();
  end
  initial begin
    {rst_i, reg_wr_i, reg_rd_i, sel} = 4'h8;
    reg_addr_i = 7'h0;
    reg_wdata_i = 16'h0;
    s_reset();
    rd(7'h44, 16'h0);
    s_write();
    s_modes();
    s_pin();
    s_readback();
    s_reset();
    give_verdict();
  end
endmodule
